//--- rtl/pbpg_params.svh
/*
  constants of the point based pulse generator: value ranges, point limits,
  clock rate and divider sizes.
  assumes it is included by its bare name from every design file that needs it.
*/
`ifndef PBPG_PARAMS_SVH
`define PBPG_PARAMS_SVH

// -------------------------------------------------------------------
// value ranges in nanoseconds
// -------------------------------------------------------------------
`define PBPG_PER_MIN_NS 37'h28
`define PBPG_PER_MAX_NS 37'h174876e800
`define PBPG_WID_MIN_NS 37'ha
`define PBPG_WID_MAX_NS 37'h174876e7ff
`define PBPG_PT_MIN_NS 37'ha
`define PBPG_LONG_NS 37'hf4240

// -------------------------------------------------------------------
// point pattern limits
// -------------------------------------------------------------------
`define PBPG_MIN_PTS 17'h4
`define PBPG_MAX_PTS 17'h186a0
`define PBPG_ONE_PT 17'h1
`define PBPG_ZERO_PT 17'h0
`define PBPG_SYNC_PTS 17'h4

// -------------------------------------------------------------------
// clock and point rate step
// -------------------------------------------------------------------
`define PBPG_CLK_NS 56'h64
`define PBPG_FRAC_BITS 32
`define PBPG_STEP_ONE 33'h100000000
`define PBPG_DIV_LAST 6'h37

// -------------------------------------------------------------------
// reset pattern: 100 us period, 10000 points, 50 us width
// -------------------------------------------------------------------
`define PBPG_RST_PER 37'h186a0
`define PBPG_RST_PTS 17'h2710
`define PBPG_RST_WID 17'h1388

`endif

//--- rtl/pbpg_pkg.sv
/*
  types of the point based pulse generator.
  assumes nothing beyond a systemverilog compiler.
*/
package pbpg_pkg;
  typedef logic [16:0] pbpg_pts_t;   // point count or index
  typedef logic [36:0] pbpg_ns_t;    // time in nanoseconds
  typedef logic [32:0] pbpg_step_t;  // point rate step, 2^32 = one per clock
  typedef logic [55:0] pbpg_dvd_t;   // divider dividend and quotient
  typedef enum logic [1:0] {PBPG_SEL_PER_PULSE, PBPG_SEL_PER_FREQ, PBPG_SEL_WIDTH, PBPG_SEL_DELAY} pbpg_sel_e;
  typedef enum {PBPG_S_IDLE, PBPG_S_RUN} pbpg_st_e;
  typedef enum {PBPG_J_NPTS, PBPG_J_STEP, PBPG_J_WSC, PBPG_J_DSC, PBPG_J_WID, PBPG_J_DLY} pbpg_job_e;
endpackage

//--- rtl/pbpg_pt_if.sv
/*
  point clock link between the pattern controller and the point clock source.
  assumes both ends run on the same clock.
*/
interface pbpg_pt_if;
  pbpg_pkg::pbpg_step_t step; // internal point rate
  logic ext_sel;              // external clocking requested
  logic ext_src;              // 1: system clock, 0: rear clock input
  logic point_en;             // one cycle pulse per point
  logic ext_active;           // external source in use
  modport ctl (output step, output ext_sel, output ext_src, input point_en, input ext_active);
  modport gen (input step, input ext_sel, input ext_src, output point_en, output ext_active);
endinterface

//--- rtl/pbpg_ptclk.sv
/*
  point clock source: rate accumulator for internal clocking, edge detector for
  the external sources, and the switch-over between them.
  assumes the external clock inputs are synchronous to clk and slower than half of it.
*/
`include "pbpg_params.svh"
module pbpg_ptclk (
  input wire logic clk,
  input wire logic rstn,
  pbpg_pt_if.gen pt,
  input wire logic rear_clk_in,
  input wire logic sys_clk_in
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic [31:0] acc;       // rate accumulator
  logic rear_prev;        // rear clock input one cycle ago
  logic sys_prev;         // system clock input one cycle ago
  logic ext_active;       // running on external edges
  logic point_en;         // registered point pulse
  logic [31:0] next_acc;
  logic next_rear_prev;
  logic next_sys_prev;
  logic next_ext_active;
  logic next_point_en;
  logic rise;             // rising edge of chosen source
  logic [32:0] sum;       // accumulator plus step

  // source choice, edge and switch-over
  always_comb begin
    // each input keeps its own history, so a change of choice never fakes an edge
    rise = pt.ext_src ? (sys_clk_in & ~sys_prev) : (rear_clk_in & ~rear_prev);
    sum = {1'b0, acc} + pt.step;
    next_rear_prev = rear_clk_in;
    next_sys_prev = sys_clk_in;
    // internal clock keeps running until the first external rise
    next_ext_active = pt.ext_sel & (ext_active | rise);
    if (ext_active) begin
      next_point_en = rise;
      next_acc = acc;
    end else begin
      next_point_en = sum[32];
      next_acc = sum[31:0];
    end
  end

  // register only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc <= 32'h0;
      rear_prev <= 1'b0;
      sys_prev <= 1'b0;
      ext_active <= 1'b0;
      point_en <= 1'b0;
    end else begin
      acc <= next_acc;
      rear_prev <= next_rear_prev;
      sys_prev <= next_sys_prev;
      ext_active <= next_ext_active;
      point_en <= next_point_en;
    end
  end

  assign pt.point_en = point_en;
  assign pt.ext_active = ext_active;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_ext_switch;
    @(posedge clk) disable iff (!rstn) (pt.ext_sel && !ext_active && rise) |=> ext_active;
  endproperty
  a_ext_switch: assert property (p_ext_switch) else $error("no switch at first external rise");

  property p_ext_point;
    @(posedge clk) disable iff (!rstn) (ext_active && pt.ext_sel) |=> (point_en == $past(rise));
  endproperty
  a_ext_point: assert property (p_ext_point) else $error("external point not one per edge");

  c_ext_switch: cover property (@(posedge clk) disable iff (!rstn) !ext_active ##1 ext_active);
endmodule

//--- rtl/pbpg_top.sv
/*
  point based pulse generator: takes period, width and delay settings, works out
  point count, point rate and realised width and delay with a shared serial
  divider, and plays back the point pattern with pulse and sync outputs.
  assumes settings are loaded one at a time while cfg_busy is low.
*/
`include "pbpg_params.svh"
module pbpg_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cfg_load,
  input wire pbpg_pkg::pbpg_sel_e cfg_sel,
  input wire logic [36:0] cfg_value,
  input wire logic cfg_neg,
  input wire logic ext_sel,
  input wire logic ext_src_sys,
  input wire logic rear_clk_in,
  input wire logic sys_clk_in,
  output logic pulse_out,
  output logic sync_out,
  output logic cfg_busy,
  output logic cfg_err,
  output logic ext_active,
  output pbpg_pkg::pbpg_pts_t point_count,
  output pbpg_pkg::pbpg_pts_t act_width_pts,
  output pbpg_pkg::pbpg_pts_t act_delay_pts,
  output logic act_delay_neg
);
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // limit a quotient to a point range
  function automatic pbpg_pkg::pbpg_pts_t clamp_pts(input pbpg_pkg::pbpg_dvd_t q,
                                                    input pbpg_pkg::pbpg_pts_t lo,
                                                    input pbpg_pkg::pbpg_pts_t hi);
    pbpg_pkg::pbpg_pts_t r;
    if (q > pbpg_pkg::pbpg_dvd_t'(hi)) r = hi;
    else if (q < pbpg_pkg::pbpg_dvd_t'(lo)) r = lo;
    else r = q[16:0];
    return r;
  endfunction

  // -------------------------------------------------------------------
  // settings engine state
  // -------------------------------------------------------------------
  pbpg_pkg::pbpg_st_e state, next_state;
  pbpg_pkg::pbpg_job_e job, next_job;
  logic [5:0] cnt, next_cnt;             // divider bit counter
  logic [36:0] rem, next_rem;            // partial remainder
  pbpg_pkg::pbpg_dvd_t quo, next_quo;    // dividend shifting into quotient
  pbpg_pkg::pbpg_ns_t den, next_den;     // divisor
  pbpg_pkg::pbpg_ns_t per_new, next_per_new;
  pbpg_pkg::pbpg_pts_t n_new, next_n_new;
  pbpg_pkg::pbpg_pts_t w_new, next_w_new;
  pbpg_pkg::pbpg_step_t step_new, next_step_new;
  pbpg_pkg::pbpg_ns_t val_ns, next_val_ns;
  logic val_neg, next_val_neg;
  logic path_freq, next_path_freq;       // period came through frequency path
  pbpg_pkg::pbpg_ns_t period, next_period;
  pbpg_pkg::pbpg_step_t step, next_step;
  pbpg_pkg::pbpg_pts_t next_point_count, next_act_width_pts, next_act_delay_pts;
  logic next_act_delay_neg, next_cfg_busy, next_cfg_err;
  logic restart, next_restart;           // pattern rebuilt, start from point 0
  logic start;                           // launch a divider job
  logic [37:0] trial;
  logic ge;
  pbpg_pkg::pbpg_dvd_t q_fin;

  // setting checks, job chaining and the serial divider
  always_comb begin
    next_state = state;
    next_job = job;
    next_cnt = cnt;
    next_rem = rem;
    next_quo = quo;
    next_den = den;
    next_per_new = per_new;
    next_n_new = n_new;
    next_w_new = w_new;
    next_step_new = step_new;
    next_val_ns = val_ns;
    next_val_neg = val_neg;
    next_path_freq = path_freq;
    next_period = period;
    next_step = step;
    next_point_count = point_count;
    next_act_width_pts = act_width_pts;
    next_act_delay_pts = act_delay_pts;
    next_act_delay_neg = act_delay_neg;
    next_cfg_err = 1'b0;
    next_restart = 1'b0;
    start = 1'b0;
    trial = {rem, quo[55]};
    ge = trial >= {1'b0, den};
    q_fin = {quo[54:0], ge};
    unique case (state)
      pbpg_pkg::PBPG_S_IDLE: begin
        if (cfg_load) begin
          unique case (cfg_sel)
            pbpg_pkg::PBPG_SEL_PER_PULSE: begin
              if (cfg_value < `PBPG_PER_MIN_NS || cfg_value > `PBPG_PER_MAX_NS) begin
                next_cfg_err = 1'b1;
              end else begin
                next_per_new = cfg_value;
                next_path_freq = 1'b0;
                next_job = pbpg_pkg::PBPG_J_NPTS;
                start = 1'b1;
              end
            end
            pbpg_pkg::PBPG_SEL_PER_FREQ: begin
              // fixed point count sets the shortest reachable period
              if (cfg_value < pbpg_pkg::pbpg_ns_t'(point_count) * `PBPG_PT_MIN_NS ||
                  cfg_value > `PBPG_PER_MAX_NS) begin
                next_cfg_err = 1'b1;
              end else begin
                next_per_new = cfg_value;
                next_n_new = point_count;
                next_path_freq = 1'b1;
                next_job = pbpg_pkg::PBPG_J_STEP;
                start = 1'b1;
              end
            end
            pbpg_pkg::PBPG_SEL_WIDTH: begin
              if (cfg_value < `PBPG_WID_MIN_NS || cfg_value > `PBPG_WID_MAX_NS) begin
                next_cfg_err = 1'b1;
              end else begin
                next_val_ns = cfg_value;
                next_job = pbpg_pkg::PBPG_J_WID;
                start = 1'b1;
              end
            end
            pbpg_pkg::PBPG_SEL_DELAY: begin
              if (cfg_value >= period) begin
                next_cfg_err = 1'b1;
              end else begin
                next_val_ns = cfg_value;
                next_val_neg = cfg_neg;
                next_job = pbpg_pkg::PBPG_J_DLY;
                start = 1'b1;
              end
            end
          endcase
        end
      end
      pbpg_pkg::PBPG_S_RUN: begin
        // loads are refused while a job runs
        next_cfg_err = cfg_load;
        next_rem = ge ? 37'(trial - {1'b0, den}) : trial[36:0];
        next_quo = q_fin;
        next_cnt = cnt + 6'h1;
        if (cnt == `PBPG_DIV_LAST) begin
          next_state = pbpg_pkg::PBPG_S_IDLE;
          unique case (job)
            pbpg_pkg::PBPG_J_NPTS: begin
              // ten ns points, capped at the full count beyond one ms
              next_n_new = clamp_pts(q_fin, `PBPG_MIN_PTS, `PBPG_MAX_PTS);
              next_job = pbpg_pkg::PBPG_J_STEP;
              start = 1'b1;
            end
            pbpg_pkg::PBPG_J_STEP: begin
              // point time = period / count, with the rate rounded down, limited to one point a clock
              next_step_new = (q_fin > pbpg_pkg::pbpg_dvd_t'(`PBPG_STEP_ONE)) ? `PBPG_STEP_ONE : q_fin[32:0];
              if (path_freq) begin
                // same count, so width and delay scale with no change in points
                next_step = next_step_new;
                next_period = per_new;
              end else begin
                next_job = pbpg_pkg::PBPG_J_WSC;
                start = 1'b1;
              end
            end
            pbpg_pkg::PBPG_J_WSC: begin
              next_w_new = clamp_pts(q_fin, `PBPG_ONE_PT, n_new);
              next_job = pbpg_pkg::PBPG_J_DSC;
              start = 1'b1;
            end
            pbpg_pkg::PBPG_J_DSC: begin
              // commit the whole new pattern at once
              next_act_delay_pts = clamp_pts(q_fin, `PBPG_ZERO_PT, n_new - `PBPG_ONE_PT);
              next_act_width_pts = w_new;
              next_point_count = n_new;
              next_step = step_new;
              next_period = per_new;
              next_restart = 1'b1;
            end
            pbpg_pkg::PBPG_J_WID: begin
              // rounds down to whole points, never below one point
              next_act_width_pts = clamp_pts(q_fin, `PBPG_ONE_PT, point_count);
            end
            pbpg_pkg::PBPG_J_DLY: begin
              next_act_delay_pts = clamp_pts(q_fin, `PBPG_ZERO_PT, point_count - `PBPG_ONE_PT);
              next_act_delay_neg = val_neg;
            end
          endcase
        end
      end
    endcase
    // operands of the job being launched
    if (start) begin
      next_state = pbpg_pkg::PBPG_S_RUN;
      next_cnt = 6'h0;
      next_rem = 37'h0;
      unique case (next_job)
        pbpg_pkg::PBPG_J_NPTS: begin
          next_quo = pbpg_pkg::pbpg_dvd_t'(next_per_new);
          next_den = `PBPG_PT_MIN_NS;
        end
        pbpg_pkg::PBPG_J_STEP: begin
          next_quo = (pbpg_pkg::pbpg_dvd_t'(next_n_new) * `PBPG_CLK_NS) << `PBPG_FRAC_BITS;
          next_den = next_per_new;
        end
        pbpg_pkg::PBPG_J_WSC: begin
          next_quo = pbpg_pkg::pbpg_dvd_t'(act_width_pts) * pbpg_pkg::pbpg_dvd_t'(n_new);
          next_den = pbpg_pkg::pbpg_ns_t'(point_count);
        end
        pbpg_pkg::PBPG_J_DSC: begin
          next_quo = pbpg_pkg::pbpg_dvd_t'(act_delay_pts) * pbpg_pkg::pbpg_dvd_t'(n_new);
          next_den = pbpg_pkg::pbpg_ns_t'(point_count);
        end
        default: begin
          // width and delay in ns map onto points of the current pattern
          next_quo = pbpg_pkg::pbpg_dvd_t'(next_val_ns) * pbpg_pkg::pbpg_dvd_t'(point_count);
          next_den = period;
        end
      endcase
    end
    next_cfg_busy = next_state == pbpg_pkg::PBPG_S_RUN;
  end

  // register only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= pbpg_pkg::PBPG_S_IDLE;
      job <= pbpg_pkg::PBPG_J_NPTS;
      cnt <= 6'h0;
      rem <= 37'h0;
      quo <= 56'h0;
      den <= `PBPG_PT_MIN_NS;
      per_new <= `PBPG_RST_PER;
      n_new <= `PBPG_RST_PTS;
      w_new <= `PBPG_RST_WID;
      step_new <= `PBPG_STEP_ONE;
      val_ns <= 37'h0;
      val_neg <= 1'b0;
      path_freq <= 1'b0;
      period <= `PBPG_RST_PER;
      step <= `PBPG_STEP_ONE;
      point_count <= `PBPG_RST_PTS;
      act_width_pts <= `PBPG_RST_WID;
      act_delay_pts <= 17'h0;
      act_delay_neg <= 1'b0;
      cfg_busy <= 1'b0;
      cfg_err <= 1'b0;
      restart <= 1'b0;
    end else begin
      state <= next_state;
      job <= next_job;
      cnt <= next_cnt;
      rem <= next_rem;
      quo <= next_quo;
      den <= next_den;
      per_new <= next_per_new;
      n_new <= next_n_new;
      w_new <= next_w_new;
      step_new <= next_step_new;
      val_ns <= next_val_ns;
      val_neg <= next_val_neg;
      path_freq <= next_path_freq;
      period <= next_period;
      step <= next_step;
      point_count <= next_point_count;
      act_width_pts <= next_act_width_pts;
      act_delay_pts <= next_act_delay_pts;
      act_delay_neg <= next_act_delay_neg;
      cfg_busy <= next_cfg_busy;
      cfg_err <= next_cfg_err;
      restart <= next_restart;
    end
  end

  // -------------------------------------------------------------------
  // point clock
  // -------------------------------------------------------------------
  pbpg_pt_if pt ();
  assign pt.step = step;
  assign pt.ext_sel = ext_sel;
  assign pt.ext_src = ext_src_sys;
  assign ext_active = pt.ext_active;
  pbpg_ptclk i_pbpg_ptclk (.clk(clk), .rstn(rstn), .pt(pt), .rear_clk_in(rear_clk_in), .sys_clk_in(sys_clk_in));

  // -------------------------------------------------------------------
  // playback
  // -------------------------------------------------------------------
  pbpg_pkg::pbpg_pts_t idx, next_idx;
  pbpg_pkg::pbpg_pts_t start_pt;   // first pulse point
  logic [17:0] rel;                // points since pulse start
  logic in_pulse, next_pulse_out, next_sync_out;

  // pulse placement and sync; outputs trail the index by one clock
  always_comb begin
    // negative delay puts the pulse that many points before the marker
    start_pt = (act_delay_neg && act_delay_pts != 17'h0) ? point_count - act_delay_pts : act_delay_pts;
    rel = (idx >= start_pt) ? 18'(idx - start_pt) : 18'({1'b0, idx} + {1'b0, point_count} - {1'b0, start_pt});
    in_pulse = rel < {1'b0, act_width_pts};
    next_pulse_out = in_pulse;
    next_sync_out = idx < `PBPG_SYNC_PTS;
    if (restart) next_idx = 17'h0;
    else if (pt.point_en) next_idx = (idx == point_count - `PBPG_ONE_PT) ? 17'h0 : idx + `PBPG_ONE_PT;
    else next_idx = idx;
  end

  // register only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx <= 17'h0;
      pulse_out <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      idx <= next_idx;
      pulse_out <= next_pulse_out;
      sync_out <= next_sync_out;
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_per_reject;
    @(posedge clk) disable iff (!rstn)
      (cfg_load && !cfg_busy && cfg_sel == pbpg_pkg::PBPG_SEL_PER_PULSE && cfg_value < `PBPG_PER_MIN_NS)
      |=> cfg_err && !cfg_busy;
  endproperty
  a_per_reject: assert property (p_per_reject) else $error("short period not refused");

  property p_wid_reject;
    @(posedge clk) disable iff (!rstn)
      (cfg_load && !cfg_busy && cfg_sel == pbpg_pkg::PBPG_SEL_WIDTH && cfg_value > `PBPG_WID_MAX_NS) |=> cfg_err;
  endproperty
  a_wid_reject: assert property (p_wid_reject) else $error("long width not refused");

  property p_dly_range;
    @(posedge clk) disable iff (!rstn) act_delay_pts < point_count;
  endproperty
  a_dly_range: assert property (p_dly_range) else $error("delay reaches a full period");

  property p_pts_range;
    @(posedge clk) disable iff (!rstn) point_count >= `PBPG_MIN_PTS && point_count <= `PBPG_MAX_PTS;
  endproperty
  a_pts_range: assert property (p_pts_range) else $error("point count out of range");

  property p_step_cap;
    @(posedge clk) disable iff (!rstn) step <= `PBPG_STEP_ONE && step != 33'h0;
  endproperty
  a_step_cap: assert property (p_step_cap) else $error("point rate out of range");

  property p_wid_range;
    @(posedge clk) disable iff (!rstn) act_width_pts >= `PBPG_ONE_PT && act_width_pts <= point_count;
  endproperty
  a_wid_range: assert property (p_wid_range) else $error("width not whole points of pattern");

  property p_long_full;
    @(posedge clk) disable iff (!rstn)
      (state == pbpg_pkg::PBPG_S_RUN && job == pbpg_pkg::PBPG_J_DSC && cnt == `PBPG_DIV_LAST && per_new > `PBPG_LONG_NS)
      |=> point_count == `PBPG_MAX_PTS;
  endproperty
  a_long_full: assert property (p_long_full) else $error("long period not at full count");

  property p_freq_keep;
    @(posedge clk) disable iff (!rstn) (path_freq && state == pbpg_pkg::PBPG_S_RUN) |=> $stable(point_count);
  endproperty
  a_freq_keep: assert property (p_freq_keep) else $error("frequency path changed point count");

  property p_sync_first;
    @(posedge clk) disable iff (!rstn)
      (pt.point_en && !restart && idx == point_count - `PBPG_ONE_PT) |=> ##1 sync_out;
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("no sync at first point");

  property p_pulse_level;
    @(posedge clk) disable iff (!rstn) (idx == start_pt && !restart) |=> pulse_out;
  endproperty
  a_pulse_level: assert property (p_pulse_level) else $error("pulse missing at delay point");

  c_pulse_load: cover property (@(posedge clk) disable iff (!rstn)
    cfg_load && cfg_sel == pbpg_pkg::PBPG_SEL_PER_PULSE ##[1:300] restart);
  c_reject: cover property (@(posedge clk) disable iff (!rstn) cfg_err);
  c_wrap: cover property (@(posedge clk) disable iff (!rstn) pulse_out ##1 !pulse_out ##[1:1000] sync_out);
endmodule

//--- rtl/pbpg_dummy_unused.sv
/*
  intentionally empty compile unit kept out of the design; holds no module.
  assumes nothing.
*/

//--- tb/pbpg_ext_clk.sv
/*
  free running external point clock source.
  assumes the bench clock edges fall on multiples of 50 ns, so a 20 ns offset keeps
  every edge of this clock away from the sampling edge.
*/
module pbpg_ext_clk #(parameter int HALF = 350) (
  output logic clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // -----------------------------------------------------------------
  // square wave, never stops and never faster than the sample limit
  // -----------------------------------------------------------------
  initial begin
    clk_out = 1'b0;
    #20;
    forever #HALF clk_out = ~clk_out;
  end
endmodule

//--- tb/test_pbpg_top.sv
/*
  bench of the point based pulse generator: loads settings, compares results.
  assumes the design package and modules are compiled first.
*/
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module test_pbpg_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, cfg_load = 1'b0, cfg_neg = 1'b0, ext_sel = 1'b0, ext_src_sys = 1'b0, got_err;
  logic [36:0] cfg_value = '0;
  pbpg_pkg::pbpg_sel_e cfg_sel = pbpg_pkg::PBPG_SEL_WIDTH;
  logic rear, sys, pulse_out, sync_out, cfg_busy, cfg_err, ext_active, act_delay_neg;
  pbpg_pkg::pbpg_pts_t point_count, act_width_pts, act_delay_pts;
  int err_total = 0, checked = 0, k;
  always #50 clk = ~clk;
  pbpg_ext_clk #(.HALF(350)) i_pbpg_ext_clk (.clk_out(rear));
  pbpg_ext_clk #(.HALF(450)) i_pbpg_ext_clk_sys (.clk_out(sys));
  pbpg_top i_pbpg_top (.clk(clk), .rstn(rstn), .cfg_load(cfg_load), .cfg_sel(cfg_sel),
    .cfg_value(cfg_value), .cfg_neg(cfg_neg), .ext_sel(ext_sel), .ext_src_sys(ext_src_sys),
    .rear_clk_in(rear), .sys_clk_in(sys), .pulse_out(pulse_out), .sync_out(sync_out),
    .cfg_busy(cfg_busy), .cfg_err(cfg_err), .ext_active(ext_active), .point_count(point_count),
    .act_width_pts(act_width_pts), .act_delay_pts(act_delay_pts), .act_delay_neg(act_delay_neg));
  // one setting: pulse load, catch the refusal flag, wait for the engine to go idle
  task load(input pbpg_pkg::pbpg_sel_e s, input logic [36:0] v, input logic n);
    @(negedge clk);
    cfg_sel = s; cfg_value = v; cfg_neg = n; cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
    // the refusal flag stands one cycle only, so catch it at the first falling edge
    got_err = cfg_err;
    for (k = 0; k < 300 && cfg_busy !== 1'b0; k++) @(negedge clk);
    if (k == 300) err_total++;
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #2000000 err_total++;
    complete_run;
  end
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    `CHK(point_count, 17'h2710)
    load(pbpg_pkg::PBPG_SEL_WIDTH, 37'h61a8, 1'b0); `CHK(act_width_pts, 17'h9c4)
    load(pbpg_pkg::PBPG_SEL_WIDTH, 37'h9, 1'b0); `CHK(got_err, 1'b1)
    load(pbpg_pkg::PBPG_SEL_DELAY, 37'h186a0, 1'b0); `CHK(got_err, 1'b1)
    load(pbpg_pkg::PBPG_SEL_DELAY, 37'h2710, 1'b1); `CHK(act_delay_pts, 17'h3e8)
    `CHK(act_delay_neg, 1'b1)
    $display("test width and delay done");
    load(pbpg_pkg::PBPG_SEL_PER_FREQ, 37'h18696, 1'b0); `CHK(got_err, 1'b1)
    load(pbpg_pkg::PBPG_SEL_PER_FREQ, 37'h30d40, 1'b0); `CHK(point_count, 17'h2710)
    load(pbpg_pkg::PBPG_SEL_PER_PULSE, 37'hc7, 1'b0); `CHK(point_count, 17'h13)
    `CHK(act_width_pts, 17'h4)
    `CHK(act_delay_pts, 17'h1)
    load(pbpg_pkg::PBPG_SEL_PER_PULSE, 37'h174876e801, 1'b0); `CHK(got_err, 1'b1)
    load(pbpg_pkg::PBPG_SEL_PER_PULSE, 37'hbebc200, 1'b0); `CHK(point_count, 17'h186a0)
    load(pbpg_pkg::PBPG_SEL_PER_PULSE, 37'h50, 1'b0); `CHK(point_count, 17'h8)
    // eight points, one point wide, no delay: pulse rises with the marker and lasts one point
    for (k = 0; k < 20 && sync_out !== 1'b0; k++) @(negedge clk);
    for (k = 0; k < 20 && sync_out !== 1'b1; k++) @(negedge clk);
    `CHK(pulse_out, 1'b1)
    @(negedge clk);
    `CHK(pulse_out, 1'b0)
    $display("test period done");
    for (int s = 0; s < 2; s++) begin
      @(negedge clk);
      ext_src_sys = s[0];
      ext_sel = 1'b1;
      for (k = 0; k < 40 && ext_active !== 1'b1; k++) @(negedge clk);
      `CHK(ext_active, 1'b1)
      // marker spans four points: 7 clocks per rear point, 9 per system clock point
      for (k = 0; k < 200 && sync_out !== 1'b0; k++) @(negedge clk);
      for (k = 0; k < 200 && sync_out !== 1'b1; k++) @(negedge clk);
      for (k = 0; k < 200 && sync_out === 1'b1; k++) @(negedge clk);
      `CHK(k, (s == 0) ? 28 : 36)
      ext_sel = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(ext_active, 1'b0)
    end
    $display("test external clock done");
    complete_run;
  end
endmodule
